// File: swpr_pin_model.sv
`timescale 1ns/100ps
// ==========================================================
// open-drain pins with pull-up and external pull-down
module swpr_pin_model (
  input wire logic [2:0] i_pin_oe,
  input wire logic [2:0] i_ext_low,
  output logic [2:0] o_pin_level
);
  // a released pin floats high through the pull-up
  assign o_pin_level = ~(i_pin_oe | i_ext_low);
endmodule : swpr_pin_model

// File: swpr_pkg.sv
package swpr_pkg;
  // ==========================================================
  // data memory map
  localparam logic [6:0] SWPR_ADDR_PORT = 7'h71;
  localparam int SWPR_PORT_W = 4;
  localparam int SWPR_PIN_W = 3;
  // ==========================================================
  // operand and pin positions
  localparam int SWPR_WAKE_SEL_BIT = 0;
  localparam int SWPR_PAUSE_PIN = 0;
  localparam int SWPR_STOP_PIN = 1;
  // ==========================================================
  // reset values
  localparam logic SWPR_OUT_MODE_RST = 1'b0;
  localparam logic [3:0] SWPR_LATCH_RST = 4'h7;
  // ==========================================================
  // timing: oscillator pulses counted before operation
  localparam int SWPR_SETTLE_PULSES = 8;
  localparam int SWPR_SETTLE_W = 4;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SWPR_OP_MOVE,
    SWPR_OP_AND,
    SWPR_OP_OR,
    SWPR_OP_XOR
  } swpr_op_e;
  typedef enum logic [1:0] {
    SWPR_ST_RUN,
    SWPR_ST_PAUSE,
    SWPR_ST_DEEP,
    SWPR_ST_SETTLE
  } swpr_state_e;
endpackage : swpr_pkg

// File: swpr_settle.sv
`timescale 1ns/100ps
module swpr_settle #(
  parameter int PULSES = swpr_pkg::SWPR_SETTLE_PULSES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  swpr_settle_if.timer settle
);
  import swpr_pkg::*;

  // ==========================================================
  // settle counter
  logic [SWPR_SETTLE_W-1:0] count_r;
  logic [SWPR_SETTLE_W-1:0] count_nxt;
  wire at_end = (count_r == SWPR_SETTLE_W'(PULSES));

  assign count_nxt = (settle.clear) ? '0 :
                     (at_end) ? count_r : count_r + 1'b1;
  assign settle.done = at_end;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt; // RULE18
    end
  end

  AST_SETTLE_COUNT: assert property (@(posedge i_clock) // RULE18
    disable iff (i_reset)
    settle.clear ##1 !settle.clear [*8] |=> settle.done)
    else $error("settle wait did not end after eight pulses");
endmodule : swpr_settle

// File: swpr_settle_if.sv
`timescale 1ns/100ps
interface swpr_settle_if;
  logic clear;
  logic done;
  modport ctrl (output clear, input done);
  modport timer (input clear, output done);
endinterface : swpr_settle_if

// File: swpr_standby.sv
// What this block does
// RULE1 - port reads return current pin levels, also in output mode
// RULE2 - bit and logic ops on the port combine pin levels, write every bit
// RULE3 - software should change port outputs with a full move
// RULE4 - software keeps input pin bits at one so pins float high
// RULE5 - pause mode freezes program counter, clock keeps running
// RULE6 - pause wake by pin skips settling, resumes at next instruction
// RULE7 - reset during pause gives normal reset, fetch from address zero
// RULE8 - deep stop halts oscillator and retains data at low supply
// RULE9 - deep stop wake by pin resumes at next instruction
// RULE10 - reset during deep stop gives normal reset from address zero
// RULE11 - pause operand upper bits zero; bit zero selects release
// RULE12 - pause with bit zero clear enters always; only reset releases
// RULE13 - pause with bit zero set and pin low enters; pin or reset wake
// RULE14 - pause with bit zero set and pin high is a no-operation
// RULE15 - wake pins sampled on the clock, high detected on any clock
// RULE16 - stop with bit zero clear resets peripherals, only reset wakes
// RULE17 - stop with bit zero set: pin high no-op, else stop till wake
// RULE18 - after reset or stop pin wake wait eight pulses before running
// RULE19 - unconditional stop clears status word, inputs mode, keeps latch
`timescale 1ns/100ps
module swpr_standby #(
  parameter int SETTLE_PULSES = swpr_pkg::SWPR_SETTLE_PULSES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [6:0] i_mem_addr,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire swpr_pkg::swpr_op_e i_mem_op,
  input wire logic [3:0] i_mem_wdata,
  output logic [3:0] o_mem_rdata,
  input wire logic i_pause_req,
  input wire logic i_stop_req,
  input wire logic [3:0] i_standby_operand,
  input wire logic [2:0] i_pin_level,
  output logic [2:0] o_pin_out,
  output logic [2:0] o_pin_oe,
  output logic o_pc_freeze,
  output logic o_core_reset,
  output logic o_resume_next,
  output logic o_no_operation,
  output logic o_osc_enable,
  output logic o_retention,
  output logic o_periph_reset,
  output logic o_psw_clear
);
  import swpr_pkg::*;

  // ==========================================================
  // pin synchroniser
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;

  always_ff @(posedge i_clock) begin
    pin_meta_r <= i_pin_level;
    pin_sync_r <= pin_meta_r; // RULE15
  end

  wire pause_wake_pin = pin_sync_r[SWPR_PAUSE_PIN];
  wire stop_wake_pin = pin_sync_r[SWPR_STOP_PIN];

  // ==========================================================
  // open-drain port latch and mode
  logic [3:0] latch_r = SWPR_LATCH_RST;
  logic [3:0] latch_nxt;
  logic out_mode_r;
  logic [3:0] rdata_r;
  logic [3:0] pin_word;
  logic [3:0] op_result;
  wire port_hit = (i_mem_addr == SWPR_ADDR_PORT);
  wire port_wr = i_mem_wr && port_hit;
  wire port_rd = i_mem_rd && port_hit;

  function automatic logic [3:0] port_alu(
    input swpr_op_e op,
    input logic [3:0] pins,
    input logic [3:0] imm
  );
    case (op)
      SWPR_OP_AND: port_alu = pins & imm;
      SWPR_OP_OR: port_alu = pins | imm;
      SWPR_OP_XOR: port_alu = pins ^ imm;
      default: port_alu = imm;
    endcase
  endfunction : port_alu

  // highest bit is not implemented and always reads zero
  assign pin_word = {1'b0, pin_sync_r};
  assign op_result = port_alu(i_mem_op, pin_word, i_mem_wdata); // RULE2
  assign latch_nxt = {1'b0, op_result[2:0]};

  // ==========================================================
  // standby sequencer
  swpr_state_e state_r;
  swpr_state_e state_nxt;
  logic from_reset_r;
  logic from_reset_nxt;
  logic resume_r;
  logic nop_r;
  logic stop_all_r;
  logic resume_nxt;
  logic nop_nxt;
  logic stop_all_nxt;
  swpr_settle_if settle_bus ();

  wire wake_sel = i_standby_operand[SWPR_WAKE_SEL_BIT];
  wire in_run = (state_r == SWPR_ST_RUN);
  wire pause_nop = i_pause_req && wake_sel && pause_wake_pin;
  wire stop_nop = i_stop_req && wake_sel && stop_wake_pin;
  wire pause_enter = i_pause_req && !pause_nop;
  wire stop_enter = i_stop_req && !stop_nop;
  wire pause_wake = (state_r == SWPR_ST_PAUSE) && from_reset_r
                    && pause_wake_pin;
  wire stop_wake = (state_r == SWPR_ST_DEEP) && from_reset_r
                   && stop_wake_pin;

  // from_reset_r doubles as the pin release enable in standby states
  always_comb begin
    state_nxt = state_r;
    from_reset_nxt = from_reset_r;
    resume_nxt = 1'b0;
    nop_nxt = 1'b0;
    stop_all_nxt = 1'b0;
    case (state_r)
      SWPR_ST_RUN: begin
        if (pause_nop || stop_nop) begin
          nop_nxt = 1'b1; // RULE14 RULE17
        end else if (pause_enter) begin
          state_nxt = SWPR_ST_PAUSE; // RULE12 RULE13
          from_reset_nxt = wake_sel;
        end else if (stop_enter) begin
          state_nxt = SWPR_ST_DEEP; // RULE17
          from_reset_nxt = wake_sel;
          stop_all_nxt = !wake_sel; // RULE16
        end
      end
      SWPR_ST_PAUSE: begin
        if (pause_wake) begin
          state_nxt = SWPR_ST_RUN; // RULE6
          resume_nxt = 1'b1;
        end
      end
      SWPR_ST_DEEP: begin
        if (stop_wake) begin
          state_nxt = SWPR_ST_SETTLE; // RULE9
          from_reset_nxt = 1'b0;
        end
      end
      SWPR_ST_SETTLE: begin
        if (settle_bus.done) begin
          state_nxt = SWPR_ST_RUN; // RULE18
          resume_nxt = !from_reset_r;
          from_reset_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = SWPR_ST_SETTLE;
        from_reset_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= SWPR_ST_SETTLE; // RULE7 RULE10
      from_reset_r <= 1'b1;
      resume_r <= 1'b0;
      nop_r <= 1'b0;
      stop_all_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      from_reset_r <= from_reset_nxt;
      resume_r <= resume_nxt;
      nop_r <= nop_nxt;
      stop_all_r <= stop_all_nxt;
    end
  end

  // ==========================================================
  // port register process
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      out_mode_r <= SWPR_OUT_MODE_RST;
      rdata_r <= 4'h0;
    end else begin
      if (stop_all_nxt) begin
        out_mode_r <= SWPR_OUT_MODE_RST; // RULE19
      end else if (port_wr && in_run) begin
        out_mode_r <= 1'b1;
      end
      rdata_r <= (port_rd) ? pin_word : 4'h0; // RULE1
    end
  end

  // latch keeps its value through reset and unconditional stop
  always_ff @(posedge i_clock) begin
    if (port_wr && in_run && !stop_all_nxt) begin
      latch_r <= latch_nxt; // RULE2
    end
  end

  // ==========================================================
  // settle timer
  assign settle_bus.clear = (state_r != SWPR_ST_SETTLE) || i_reset;

  swpr_settle #(
    .PULSES(SETTLE_PULSES)
  ) u_settle (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .settle(settle_bus)
  );

  // ==========================================================
  // outputs
  assign o_mem_rdata = rdata_r;
  assign o_pin_out = 3'h0;
  assign o_pin_oe = {3{out_mode_r}} & ~latch_r[2:0];
  assign o_pc_freeze = !in_run; // RULE5
  assign o_core_reset = i_reset
                        || ((state_r == SWPR_ST_SETTLE) && from_reset_r);
  assign o_resume_next = resume_r;
  assign o_no_operation = nop_r;
  assign o_osc_enable = (state_r != SWPR_ST_DEEP); // RULE8
  assign o_retention = (state_r == SWPR_ST_DEEP); // RULE8
  assign o_periph_reset = stop_all_r; // RULE16
  assign o_psw_clear = stop_all_r; // RULE19

  // ==========================================================
  // assertions
  AST_READ_PINS: assert property (@(posedge i_clock) // RULE1
    disable iff (i_reset)
    port_rd |=> o_mem_rdata == {1'b0, $past(pin_sync_r)})
    else $error("port read did not return pin levels");

  AST_RMW_FROM_PINS: assert property (@(posedge i_clock) // RULE2
    disable iff (i_reset)
    port_wr && in_run && i_mem_op == SWPR_OP_AND
    |=> latch_r == {1'b0, $past(pin_sync_r) & $past(i_mem_wdata[2:0])})
    else $error("logic op did not use pin levels");

  AST_PAUSE_CLOCK: assert property (@(posedge i_clock) // RULE5
    disable iff (i_reset)
    state_r == SWPR_ST_PAUSE |-> o_pc_freeze && o_osc_enable)
    else $error("pause mode must freeze pc with clock running");

  AST_PAUSE_PIN_WAKE: assert property (@(posedge i_clock) // RULE6
    disable iff (i_reset)
    pause_wake |=> o_resume_next && !o_pc_freeze && !o_core_reset)
    else $error("pause pin wake did not resume at once");

  AST_RESET_RESTART: assert property (@(posedge i_clock) // RULE7
    i_reset |=> o_core_reset && o_pc_freeze && !o_resume_next)
    else $error("reset did not restart from address zero");

  AST_DEEP_OSC: assert property (@(posedge i_clock) // RULE8
    disable iff (i_reset)
    state_r == SWPR_ST_DEEP |-> !o_osc_enable && o_retention)
    else $error("deep stop must halt the oscillator");

  AST_STOP_WAKE_SETTLE: assert property (@(posedge i_clock) // RULE18
    disable iff (i_reset)
    stop_wake |=> !o_resume_next [*8] ##[1:3] o_resume_next)
    else $error("stop pin wake did not settle then resume");

  AST_PAUSE_RESET_ONLY: assert property (@(posedge i_clock) // RULE12
    disable iff (i_reset)
    in_run && pause_enter && !wake_sel |=> state_r == SWPR_ST_PAUSE
    ##1 state_r == SWPR_ST_PAUSE)
    else $error("unconditional pause released without reset");

  AST_PAUSE_NOP: assert property (@(posedge i_clock) // RULE14
    disable iff (i_reset)
    in_run && pause_nop |=> o_no_operation && !o_pc_freeze)
    else $error("pause with high pin must be a no-operation");

  AST_STOP_ALL: assert property (@(posedge i_clock) // RULE16 RULE19
    disable iff (i_reset)
    in_run && stop_enter && !wake_sel
    |=> o_periph_reset && o_psw_clear && !out_mode_r && o_retention)
    else $error("unconditional stop did not clear state");

  AST_STOP_NOP: assert property (@(posedge i_clock) // RULE17
    disable iff (i_reset)
    in_run && stop_nop |=> o_no_operation && o_osc_enable)
    else $error("stop with high pin must be a no-operation");

  COV_PAUSE_WAKE: cover property (@(posedge i_clock) disable iff (i_reset)
    pause_wake ##1 o_resume_next);
  COV_STOP_WAKE: cover property (@(posedge i_clock) disable iff (i_reset)
    stop_wake ##[9:12] o_resume_next);
  COV_STOP_ALL: cover property (@(posedge i_clock) disable iff (i_reset)
    o_periph_reset);
  COV_PORT_RMW: cover property (@(posedge i_clock) disable iff (i_reset)
    port_wr && in_run && i_mem_op != SWPR_OP_MOVE);
endmodule : swpr_standby

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  import swpr_pkg::*;
  logic i_clock = 1'h0;
  logic i_reset = 1'h1;
  logic [6:0] i_mem_addr = SWPR_ADDR_PORT;
  logic i_mem_rd = 1'h0;
  logic i_mem_wr = 1'h0;
  swpr_op_e i_mem_op = SWPR_OP_MOVE;
  logic [3:0] i_mem_wdata = 4'h0;
  logic [3:0] i_standby_operand = 4'h0;
  logic i_pause_req = 1'h0;
  logic i_stop_req = 1'h0;
  logic [2:0] ext_low = 3'h0;
  wire [2:0] pin_level;
  wire [2:0] pin_oe;
  wire [2:0] pin_out;
  wire [3:0] rdata;
  wire freeze, core_rst, resume, no_operation, osc_en, ret, per_rst, psw_clr;
  wire [2:0] mon = {~freeze, ~core_rst, resume};
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int lo = SWPR_SETTLE_PULSES;
  int hi = SWPR_SETTLE_PULSES + 6;
  swpr_standby #(.SETTLE_PULSES(SWPR_SETTLE_PULSES)) swpr_standby_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_mem_addr(i_mem_addr),
    .i_mem_rd(i_mem_rd), .i_mem_wr(i_mem_wr), .i_mem_op(i_mem_op),
    .i_mem_wdata(i_mem_wdata), .o_mem_rdata(rdata),
    .i_pause_req(i_pause_req), .i_stop_req(i_stop_req),
    .i_standby_operand(i_standby_operand), .i_pin_level(pin_level),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pc_freeze(freeze),
    .o_core_reset(core_rst), .o_resume_next(resume),
    .o_no_operation(no_operation), .o_osc_enable(osc_en), .o_retention(ret),
    .o_periph_reset(per_rst), .o_psw_clear(psw_clr));
  swpr_pin_model swpr_pin_model_inst (.i_pin_oe(pin_oe),
    .i_ext_low(ext_low), .o_pin_level(pin_level));
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [3:0] exp,
                     input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic drive_pins(input logic [2:0] v);
    @(posedge i_clock);
    ext_low <= v;
  endtask : drive_pins
  task automatic wait_for(input int k, input int lim);
    n = 0;
    while (mon[k] !== 1'h1 && n < lim) begin
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask : wait_for
  task automatic wr(input swpr_op_e op, input logic [3:0] d);
    repeat (3) @(posedge i_clock);
    i_mem_op <= op;
    i_mem_wdata <= d;
    i_mem_wr <= 1'h1;
    @(posedge i_clock);
    i_mem_wr <= 1'h0;
    @(posedge i_clock);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [3:0] exp);
    repeat (3) @(posedge i_clock);
    i_mem_addr <= a;
    i_mem_rd <= 1'h1;
    @(posedge i_clock);
    i_mem_rd <= 1'h0;
    i_mem_addr <= SWPR_ADDR_PORT;
    #1;
    chk("port read", exp, rdata);
  endtask : rd
  task automatic req(input logic stop, input logic [3:0] opd);
    repeat (3) @(posedge i_clock);
    i_standby_operand <= opd;
    if (stop) i_stop_req <= 1'h1;
    else i_pause_req <= 1'h1;
    @(posedge i_clock);
    i_stop_req <= 1'h0;
    i_pause_req <= 1'h0;
    #1;
  endtask : req
  task automatic do_reset;
    @(posedge i_clock);
    i_reset <= 1'h1;
    @(posedge i_clock);
    i_reset <= 1'h0;
    #1;
    chk("core reset", 4'h3, {2'h0, core_rst, freeze});
    wait_for(1, 40);
    chk("reset settle", 4'h1, {3'h0, n >= lo && n <= hi});
    wait_for(2, 5);
  endtask : do_reset
  // ==========================================================
  // scenarios
  task automatic t_port;
    drive_pins(3'h3);
    rd(SWPR_ADDR_PORT, 4'h4);
    rd(7'h70, 4'h0);
    wr(SWPR_OP_AND, 4'hb);
    chk("and oe", 4'h7, {1'h0, pin_oe});
    chk("pin out", 4'h0, {1'h0, pin_out});
    drive_pins(3'h0);
    wr(SWPR_OP_MOVE, 4'hb);
    chk("move oe", 4'h4, {1'h0, pin_oe});
    rd(SWPR_ADDR_PORT, 4'h3);
    wr(SWPR_OP_XOR, 4'h1);
    chk("xor oe", 4'h5, {1'h0, pin_oe});
    wr(SWPR_OP_OR, 4'h4);
    chk("or oe", 4'h1, {1'h0, pin_oe});
    wr(SWPR_OP_MOVE, 4'hf);
  endtask : t_port
  task automatic t_pause;
    req(1'h0, 4'h1);
    chk("pause nop", 4'h1, {3'h0, no_operation});
    drive_pins(3'h1);
    req(1'h0, 4'h1);
    chk("pause entry", 4'h3, {2'h0, freeze, osc_en});
    drive_pins(3'h0);
    wait_for(0, 10);
    chk("pause wake", 4'h1, {3'h0, n <= 4});
    req(1'h0, 4'h0);
    repeat (8) @(posedge i_clock);
    #1;
    chk("pause hold", 4'h1, {3'h0, freeze});
    do_reset;
  endtask : t_pause
  task automatic t_stop;
    req(1'h1, 4'h1);
    chk("stop nop", 4'h1, {3'h0, no_operation});
    drive_pins(3'h2);
    req(1'h1, 4'h1);
    chk("stop entry", 4'h6, {1'h0, freeze, ret, osc_en});
    drive_pins(3'h0);
    wait_for(0, 40);
    chk("stop wake", 4'h1, {3'h0, n >= lo && n <= hi});
    wr(SWPR_OP_MOVE, 4'h6);
    req(1'h1, 4'h0);
    chk("stop clear", 4'he, {per_rst, psw_clr, ret, |pin_oe});
    do_reset;
  endtask : t_stop
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    do_reset;
    t_port;
    t_pause;
    t_stop;
    give_verdict;
  end
endmodule : testbench
